// ==== cbc_regs.vh ====
// register offsets, field positions and reset values of the clock buffer control bank
`ifndef CBC_REGS_VH
`define CBC_REGS_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CBC_OFS_PATH_BW 8'h00
`define CBC_OFS_OUT_EN 8'h01
`define CBC_OFS_RSVD_A 8'h02
`define CBC_OFS_RSVD_B 8'h03
`define CBC_OFS_MAKER_ID 8'h04
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CBC_BIT_PATH_SEL 1
`define CBC_BIT_PLL_BW 2
`define CBC_BIT_POWERDOWN_DRIVE_MODE 7
`define CBC_BIT_OE0 1
`define CBC_BIT_OE1 2
`define CBC_BIT_OE2 5
`define CBC_BIT_OE3 6
// writable masks of bytes 0 and 1
`define CBC_MASK_PATH_BW 8'h86
`define CBC_MASK_OUT_EN 8'h66
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CBC_RST_PATH_BW 8'h06
`define CBC_RST_OUT_EN 8'h66
`define CBC_RST_RSVD_B 8'h00
// ------------------------------------------------------------
// smbus constants
// ------------------------------------------------------------
`define CBC_SLAVE_ADDR 7'h6E
`define CBC_LAST_OFS 8'h04
`endif

// ==== cbc_ctrl.v ====
// smbus slave with the clock buffer control and identification register bank
`include "cbc_regs.vh"

// Behaviour
// - byte0 path and bandwidth bits, reset one
// - byte0 bit7 powerdown drive mode, reset zero
// - byte1 per-pair output enables, reset enabled
// - byte2 fully reserved, no effect
// - byte4 read-only identification, writes ignored
// - fixed-address slave, indexed block read/write
// - stop after any byte ends transfer cleanly
// - no register access during powerdown
module cbc_ctrl #(
  parameter [7:0] MAKER_ID = 8'hA5 // arbitrary identification value
) (
  input wire CLK,
  input wire NRST,
  input wire SCL,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire POWERDOWN_INPUT_N,
  output wire PATH_PLL,
  output wire PLL_BW_LOW,
  output wire POWERDOWN_DRIVE_MODE,
  output wire [3:0] OUT_ENABLE
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0; // wait for start
  localparam [2:0] ST_RX = 3'h1; // shifting a byte in
  localparam [2:0] ST_ACK = 3'h2; // driving ack low
  localparam [2:0] ST_TX = 3'h3; // shifting a byte out
  localparam [2:0] ST_RACK = 3'h4; // sampling master ack
  localparam [2:0] ST_SKIP = 3'h5; // not addressed, wait stop

  // phase within a write transfer
  localparam [1:0] PH_ADDR = 2'h0;
  localparam [1:0] PH_OFS = 2'h1;
  localparam [1:0] PH_CNT = 2'h2;
  localparam [1:0] PH_DATA = 2'h3;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg scl_ff, sda_ff; // last sampled line levels
  reg [2:0] st_ff, nxt_st;
  reg [1:0] ph_ff, nxt_ph;
  reg [3:0] bit_ff, nxt_bit; // scl rises seen in a received byte, scl falls in a sent one
  reg [7:0] sh_ff, nxt_sh; // shift register
  reg [7:0] ptr_ff, nxt_ptr; // register index
  reg rd_ff, nxt_rd; // current transfer is a read
  reg cnt_sent_ff, nxt_cnt_sent; // read count byte already sent
  reg sda_low_ff, nxt_sda_low; // pulling sda low
  reg [7:0] b0_ff, b1_ff, b3_ff; // stored bytes
  reg wr_ff, nxt_wr; // one-cycle write strobe
  reg [7:0] wdat_ff, nxt_wdat;
  reg [7:0] wofs_ff, nxt_wofs;

  wire scl_rise = SCL & ~scl_ff;
  wire scl_fall = ~SCL & scl_ff;
  wire start_c = SCL & scl_ff & sda_ff & ~SDA_IN;
  wire stop_c = SCL & scl_ff & ~sda_ff & SDA_IN;
  wire active = POWERDOWN_INPUT_N;

  // register read mux; reserved bits of bytes 0 to 2 read zero, byte 3 reads back as written
  function [7:0] rd_byte;
    input [7:0] ofs;
    begin
      case (ofs)
        `CBC_OFS_PATH_BW: rd_byte = b0_ff & `CBC_MASK_PATH_BW;
        `CBC_OFS_OUT_EN: rd_byte = b1_ff & `CBC_MASK_OUT_EN;
        `CBC_OFS_RSVD_A: rd_byte = 8'h00;
        `CBC_OFS_RSVD_B: rd_byte = b3_ff;
        `CBC_OFS_MAKER_ID: rd_byte = MAKER_ID;
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // line sampling
  // ------------------------------------------------------------
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= SCL;
      sda_ff <= SDA_IN;
    end
  end

  // ------------------------------------------------------------
  // protocol engine
  // ------------------------------------------------------------
  always @* begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_rd = rd_ff;
    nxt_cnt_sent = cnt_sent_ff;
    nxt_sda_low = sda_low_ff;
    nxt_wr = 1'b0;
    nxt_wdat = wdat_ff;
    nxt_wofs = wofs_ff;
    if (!active || stop_c) begin
      // stop or powerdown aborts, written bytes stay
      nxt_st = ST_IDLE;
      nxt_sda_low = 1'b0;
    end else if (start_c) begin
      // start or repeated start: expect address
      nxt_st = ST_RX;
      nxt_ph = PH_ADDR;
      nxt_bit = 4'h0;
      nxt_sda_low = 1'b0;
    end else begin
      case (st_ff)
        ST_RX: begin
          if (scl_rise) begin
            // sample on the rising clock, msb first
            nxt_sh = {sh_ff[6:0], SDA_IN};
            nxt_bit = bit_ff + 4'h1;
          end
          // byte complete at the fall after the eighth rise; the fall after start is skipped
          if (scl_fall && bit_ff == 4'h8) begin
            case (ph_ff)
              PH_ADDR: begin
                if (sh_ff[7:1] == `CBC_SLAVE_ADDR) begin
                  nxt_rd = sh_ff[0];
                  nxt_cnt_sent = 1'b0;
                  nxt_ph = PH_OFS;
                  nxt_st = ST_ACK;
                  nxt_sda_low = 1'b1;
                end else begin
                  nxt_st = ST_SKIP;
                end
              end
              PH_OFS: begin
                nxt_ptr = sh_ff;
                nxt_ph = PH_CNT;
                nxt_st = ST_ACK;
                nxt_sda_low = 1'b1;
              end
              PH_CNT: begin
                // count is acknowledged; transfer ends by stop
                nxt_ph = PH_DATA;
                nxt_st = ST_ACK;
                nxt_sda_low = 1'b1;
              end
              default: begin
                nxt_wr = 1'b1;
                nxt_wdat = sh_ff;
                nxt_wofs = ptr_ff;
                nxt_ptr = ptr_ff + 8'h01;
                nxt_st = ST_ACK;
                nxt_sda_low = 1'b1;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_bit = 4'h0;
            if (rd_ff && ph_ff == PH_OFS) begin
              // block read: byte count first, then data from the latched offset
              nxt_st = ST_TX;
              nxt_sh = `CBC_LAST_OFS + 8'h01; // count covers offsets 0 to last
              nxt_sda_low = ~nxt_sh[7];
            end else begin
              nxt_st = ST_RX;
              nxt_sda_low = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
              nxt_st = ST_RACK;
              nxt_sda_low = 1'b0;
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_sda_low = ~sh_ff[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (SDA_IN) begin
              nxt_st = ST_SKIP; // master nack ends read
            end
          end else if (scl_fall) begin
            nxt_st = ST_TX;
            nxt_bit = 4'h0;
            if (cnt_sent_ff) begin
              nxt_ptr = ptr_ff + 8'h01;
              nxt_sh = rd_byte(ptr_ff + 8'h01);
            end else begin
              nxt_sh = rd_byte(ptr_ff);
            end
            nxt_cnt_sent = 1'b1;
            nxt_sda_low = ~nxt_sh[7];
          end
        end
        default: begin
          nxt_sda_low = 1'b0; // idle or skip: hands off the line
        end
      endcase
    end
  end

  // state and shift registers
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= ST_IDLE;
      ph_ff <= PH_ADDR;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rd_ff <= 1'b0;
      cnt_sent_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdat_ff <= 8'h00;
      wofs_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      rd_ff <= nxt_rd;
      cnt_sent_ff <= nxt_cnt_sent;
      sda_low_ff <= nxt_sda_low;
      wr_ff <= nxt_wr;
      wdat_ff <= nxt_wdat;
      wofs_ff <= nxt_wofs;
    end
  end

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      b0_ff <= `CBC_RST_PATH_BW;
      b1_ff <= `CBC_RST_OUT_EN;
      b3_ff <= `CBC_RST_RSVD_B;
    end else if (wr_ff && active) begin
      case (wofs_ff)
        `CBC_OFS_PATH_BW: b0_ff <= wdat_ff & `CBC_MASK_PATH_BW;
        `CBC_OFS_OUT_EN: b1_ff <= wdat_ff & `CBC_MASK_OUT_EN;
        `CBC_OFS_RSVD_B: b3_ff <= wdat_ff;
        default: b3_ff <= b3_ff; // byte 2 and id ignore writes
      endcase
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_low_ff;
  assign PATH_PLL = b0_ff[`CBC_BIT_PATH_SEL];
  assign PLL_BW_LOW = b0_ff[`CBC_BIT_PLL_BW];
  assign POWERDOWN_DRIVE_MODE = b0_ff[`CBC_BIT_POWERDOWN_DRIVE_MODE];
  assign OUT_ENABLE = {b1_ff[`CBC_BIT_OE3], b1_ff[`CBC_BIT_OE2], b1_ff[`CBC_BIT_OE1], b1_ff[`CBC_BIT_OE0]};

endmodule // cbc_ctrl

// ==== cbc_monitor.sv ====
// port checker of the clock buffer control bank
module cbc_monitor (
  input wire CLK,
  input wire NRST,
  input wire SCL,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire POWERDOWN_INPUT_N,
  input wire PATH_PLL,
  input wire PLL_BW_LOW,
  input wire POWERDOWN_DRIVE_MODE,
  input wire [3:0] OUT_ENABLE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // one clock domain, reset disables all
  // ----------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  chk_reset_vals: assert property ($rose(NRST) |-> PATH_PLL && PLL_BW_LOW && !POWERDOWN_DRIVE_MODE
    && OUT_ENABLE == 4'hF) else $error("config not at reset values");
  chk_oe_after_fall: assert property ($changed(SDA_OE) |-> !SCL && ($past(SCL, 2) || $past(SCL, 3) || $past(SCL, 4)))
    else $error("sda drive changed away from an scl fall");
  chk_oe_high_stable: assert property (SCL && $past(SCL) |-> $stable(SDA_OE))
    else $error("sda drive changed while scl high");
  chk_oe_bounded: assert property ($rose(SDA_OE) |-> ##[1:300] !SDA_OE)
    else $error("sda held low too long");
  chk_pd_no_ack: assert property (!POWERDOWN_INPUT_N [*3] |-> !SDA_OE)
    else $error("sda driven during powerdown");
  chk_pd_cfg_hold: assert property (!POWERDOWN_INPUT_N [*4] |->
    $stable({PATH_PLL, PLL_BW_LOW, POWERDOWN_DRIVE_MODE, OUT_ENABLE})) else $error("config moved in powerdown");
  chk_cfg_scl_low: assert property (!$stable({PATH_PLL, PLL_BW_LOW, POWERDOWN_DRIVE_MODE, OUT_ENABLE}) |-> !SCL)
    else $error("config changed while scl high");
  chk_open_drain: assert property (SDA_OUT == 1'b0)
    else $error("sda output not low");
  // a stop condition on the line always leaves the data line released
  chk_stop_release: assert property (SCL && $past(SCL) && SDA_IN && !$past(SDA_IN) |=> !SDA_OE)
    else $error("sda still driven after stop");
endmodule // cbc_monitor

bind cbc_ctrl cbc_monitor cbc_monitor_i (.CLK(CLK), .NRST(NRST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .POWERDOWN_INPUT_N(POWERDOWN_INPUT_N), .PATH_PLL(PATH_PLL), .PLL_BW_LOW(PLL_BW_LOW),
  .POWERDOWN_DRIVE_MODE(POWERDOWN_DRIVE_MODE), .OUT_ENABLE(OUT_ENABLE));

// ==== cbc_host.sv ====
// smbus host model that drives the bank's serial port
module cbc_host (
  input wire clk,
  input wire sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // third of a bit time
  task automatic q;
    repeat (8) @(posedge clk);
  endtask
  // one bit: data moves while scl low, read in scl high
  task automatic bt(input logic b, output logic r);
    sda_low <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    scl <= 1'b0;
    q();
  endtask
  task automatic frame_start;
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  // stop may follow any whole byte
  task automatic frame_stop;
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  // byte out msb first, ack read back
  task automatic tx(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    a = ~r;
  endtask
  // byte in, host nacks the last one
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, r);
      d[i] = r;
    end
    bt(last, r);
  endtask
  // write frame of the first n bytes; counts sent are never zero
  task automatic wr(input logic [7:0] b[8], input int n, output logic ack);
    logic a;
    ack = 1'b1;
    frame_start();
    for (int i = 0; i < n; i++) begin
      tx(b[i], a);
      ack &= a;
    end
    frame_stop();
  endtask
  // read frame of n bytes at the fixed address; ack tells whether the address was taken
  task automatic rd(input int n, output logic [7:0] d[8], output logic ack);
    logic [7:0] v;
    frame_start();
    tx(8'hDD, ack);
    for (int i = 0; i < 8; i++) d[i] = 8'h00;
    for (int i = 0; i < n; i++) begin
      rx(i == n - 1, v);
      d[i] = v;
    end
    frame_stop();
  endtask
endmodule // cbc_host

// ==== cbc_ctrl_bench.sv ====
// self-checking bench of the clock buffer control bank
module cbc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pd_n = 1'b1;
  localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary identification value for this bench
  logic ack;
  logic [7:0] rdq[8];
  // count byte, then bytes 0 to 4
  logic [7:0] exp_rd[6] = '{8'h05, 8'h86, 8'h66, 8'h00, 8'h5A, ID_VAL};
  logic [7:0] exp_rst[6] = '{8'h05, 8'h06, 8'h66, 8'h00, 8'h00, ID_VAL};
  int err_count = 0;
  int n_compared = 0;
  wire scl, sda_low, sda_out, sda_oe, path_pll, bw_low, powerdown_drive_mode;
  wire [3:0] oe;
  // open-drain data line with pull-up
  wire sda = ~(sda_oe | sda_low);
  wire [7:0] cfgv = {powerdown_drive_mode, bw_low, path_pll, 1'b0, oe};
  cbc_ctrl #(.MAKER_ID(ID_VAL)) cbc_ctrl_i (.CLK(clk), .NRST(nrst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe),
    .POWERDOWN_INPUT_N(pd_n), .PATH_PLL(path_pll), .PLL_BW_LOW(bw_low), .POWERDOWN_DRIVE_MODE(powerdown_drive_mode),
    .OUT_ENABLE(oe));
  cbc_host cbc_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset cfg", cfgv, 8'h6F);
    $display("test reset done");
    cbc_host_i.wr('{8'hDC, 8'h00, 8'h05, 8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'h00}, 8, ack);
    chk("full write ack", ack, 8'h01);
    chk("all set cfg", cfgv, 8'hEF);
    cbc_host_i.wr('{8'hDC, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 2, ack);
    chk("offset write ack", ack, 8'h01);
    cbc_host_i.rd(6, rdq, ack);
    chk("read address ack", ack, 8'h01);
    foreach (exp_rd[i]) chk("readback", rdq[i], exp_rd[i]);
    $display("test block write and read done");
    cbc_host_i.wr('{8'hDC, 8'h00, 8'h02, 8'h00, 8'h24, 8'h00, 8'h00, 8'h00}, 5, ack);
    chk("cleared cfg", cfgv, 8'h06);
    cbc_host_i.wr('{8'hDA, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00}, 4, ack);
    chk("foreign ack", ack, 8'h00);
    chk("foreign cfg", cfgv, 8'h06);
    cbc_host_i.wr('{8'hDC, 8'h00, 8'h02, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00}, 4, ack);
    chk("short frame cfg", cfgv, 8'h86);
    $display("test addressing and early stop done");
    pd_n <= 1'b0;
    cbc_host_i.wr('{8'hDC, 8'h00, 8'h01, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00}, 4, ack);
    chk("powerdown ack", ack, 8'h00);
    chk("powerdown cfg", cfgv, 8'h86);
    cbc_host_i.rd(1, rdq, ack);
    chk("powerdown read ack", ack, 8'h00);
    chk("powerdown read data", rdq[0], 8'hFF);
    pd_n <= 1'b1;
    $display("test powerdown done");
    // second reset in mid-run: bank and index return to power-up state
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("second reset cfg", cfgv, 8'h6F);
    cbc_host_i.rd(6, rdq, ack);
    chk("reset read ack", ack, 8'h01);
    foreach (exp_rst[i]) chk("reset readback", rdq[i], exp_rst[i]);
    $display("test second reset done");
    summarize();
  end
  // watchdog well past the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule // cbc_ctrl_bench
